// File: logic/fpc_pkg.sv
// Constants for the fan drive channel configuration block
package fpc_pkg;
  localparam int NUM_CH = 3;
  // Register offsets
  localparam logic [7:0] OFS_CPU_LOW  = 8'h34;
  localparam logic [7:0] OFS_CFG_ONE  = 8'h5c;
  localparam logic [7:0] OFS_CFG_TWO  = 8'h5d;
  localparam logic [7:0] OFS_CFG_THR  = 8'h5e;
  // Reset values
  localparam logic [7:0] RST_CFG      = 8'h62;
  localparam logic [7:0] RST_CPU_LOW  = 8'h81;
  // Field positions
  localparam int SPIN_LSB  = 0;
  localparam int SPIN_W    = 3;
  localparam int ALT_BIT   = 3;
  localparam int FLIP_BIT  = 4;
  localparam int SRC_LSB   = 5;
  localparam int SRC_W     = 3;
  // Control source codes and the no-spin-up code
  localparam logic [2:0] SRC_A  = 3'h0;
  localparam logic [2:0] SRC_B  = 3'h1;
  localparam logic [2:0] SRC_C  = 3'h2;
  localparam logic [2:0] SRC_D  = 3'h3;
  localparam logic [2:0] SRC_E  = 3'h4;
  localparam logic [2:0] SRC_F  = 3'h5;
  localparam logic [2:0] SRC_G  = 3'h6;
  localparam logic [2:0] SRC_H  = 3'h7;
  localparam logic [2:0] SPIN_NONE = 3'h0;
  // Duty and count limits
  localparam logic [7:0]  DUTY_FULL  = 8'hff;
  localparam logic [7:0]  DUTY_OFF   = 8'h00;
  localparam logic [15:0] FAN_SPEED_INPUT_ALL1  = 16'hffff;
  localparam logic [15:0] FAN_SPEED_INPUT_ALL0  = 16'h0000;
  localparam logic [1:0]  EDGES_OK   = 2'h2;
  // Spin-up periods in milliseconds
  localparam logic [11:0] SPIN_MS_1 = 12'd100;
  localparam logic [11:0] SPIN_MS_2 = 12'd250;
  localparam logic [11:0] SPIN_MS_3 = 12'd400;
  localparam logic [11:0] SPIN_MS_4 = 12'd667;
  localparam logic [11:0] SPIN_MS_5 = 12'd1000;
  localparam logic [11:0] SPIN_MS_6 = 12'd2000;
  localparam logic [11:0] SPIN_MS_7 = 12'd4000;
  // Clock and millisecond tick
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_IN_PS      = 1000000000;
  localparam int MS_CYCLES     = MS_IN_PS / CLK_PERIOD_PS;
  typedef enum logic [1:0] {SU_IDLE, SU_SPIN, SU_MEAS} fpc_su_type;
endpackage : fpc_pkg

// File: logic/fpc_channel_config.sv
// Fan drive channel configuration, spin-up and source selection
`timescale 1ns/10ps
module fpc_channel_config #(
  parameter int MS_CYCLES = fpc_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  // Register port from serial management engine
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [7:0]           reg_rdata_o,
  input  wire logic                 lock_i,
  // Automatic duties from temperature paths, plus per-channel manual duties
  input  wire logic [7:0]           remote_one_duty_i,
  input  wire logic [7:0]           local_duty_i,
  input  wire logic [7:0]           remote_two_duty_i,
  input  wire logic [7:0]           cpu_reading_zero_duty_i,
  input  wire logic [7:0]           cpu_reading_one_duty_i,
  input  wire logic [7:0]           cpu_reading_two_duty_i,
  input  wire logic [7:0]           cpu_reading_three_duty_i,
  input  wire logic [2:0][7:0]      manual_duty_i,
  // Fan tachometer side
  input  wire logic [2:0]           fan_speed_input_i,
  input  wire logic [2:0]           spin_req_i,
  input  wire logic [2:0]           meas_done_i,
  input  wire logic [2:0]           fan_speed_input_valid_i,
  input  wire logic [2:0][15:0]     fan_speed_input_count_i,
  input  wire logic [2:0][15:0]     fan_speed_input_min_i,
  input  wire logic [2:0]           fault_clr_i,
  // Per channel results and the CPU low limit
  output logic      [2:0][7:0]      duty_o,
  output logic      [2:0]           polarity_flip_o,
  output logic      [2:0]           spin_hold_o,
  output logic      [2:0]           channel_off_o,
  output logic      [2:0]           manual_mode_o,
  output logic      [2:0][15:0]     fan_speed_input_count_o,
  output logic      [2:0]           fan_fault_o,
  output logic      [7:0]           cpu_low_limit_o
);

  logic [7:0]              cfg_r [fpc_pkg::NUM_CH];
  logic [7:0]              cpu_low_r;
  logic [31:0]             ms_cnt_r;
  logic                    ms_tick_r;
  logic [2:0]              sync1_r;
  logic [2:0]              sync2_r;
  logic [2:0]              sync3_r;
  logic [2:0]              fan_speed_input_rise;
  fpc_pkg::fpc_su_type     su_r [fpc_pkg::NUM_CH];
  logic [11:0]             el_ms_r [fpc_pkg::NUM_CH];
  logic [1:0]              edges_r [fpc_pkg::NUM_CH];
  logic [2:0]              hold_r;
  logic [2:0]              ovr_r;
  logic [2:0]              fault_r;
  logic [2:0]              was_off_r;

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction : max8

  function automatic logic [11:0] spin_ms(input logic [2:0] code);
    case (code)
      3'h1:    spin_ms = fpc_pkg::SPIN_MS_1;
      3'h2:    spin_ms = fpc_pkg::SPIN_MS_2;
      3'h3:    spin_ms = fpc_pkg::SPIN_MS_3;
      3'h4:    spin_ms = fpc_pkg::SPIN_MS_4;
      3'h5:    spin_ms = fpc_pkg::SPIN_MS_5;
      3'h6:    spin_ms = fpc_pkg::SPIN_MS_6;
      3'h7:    spin_ms = fpc_pkg::SPIN_MS_7;
      default: spin_ms = 12'h000;
    endcase
  endfunction : spin_ms

  function automatic logic [2:0] src_of(input logic [7:0] cfg);
    src_of = cfg[fpc_pkg::SRC_LSB +: fpc_pkg::SRC_W];
  endfunction : src_of

  function automatic logic is_off(input logic [7:0] cfg);
    is_off = !cfg[fpc_pkg::ALT_BIT] && (src_of(cfg) == fpc_pkg::SRC_E);
  endfunction : is_off

  function automatic logic is_manual(input logic [7:0] cfg);
    is_manual = !cfg[fpc_pkg::ALT_BIT] && (src_of(cfg) == fpc_pkg::SRC_H);
  endfunction : is_manual

  // Source decode for one channel
  function automatic logic [7:0] pick_duty(input logic [7:0] cfg, input logic [7:0] man);
    logic [7:0] cpu_max;
    logic [7:0] sens_max;
    cpu_max  = max8(max8(cpu_reading_zero_duty_i, cpu_reading_one_duty_i),
                    max8(cpu_reading_two_duty_i, cpu_reading_three_duty_i));
    sens_max = max8(remote_one_duty_i, max8(local_duty_i, remote_two_duty_i));
    pick_duty = fpc_pkg::DUTY_FULL;
    if (!cfg[fpc_pkg::ALT_BIT])
    begin
      case (src_of(cfg))
        fpc_pkg::SRC_A: pick_duty = remote_one_duty_i;
        fpc_pkg::SRC_B: pick_duty = local_duty_i;
        fpc_pkg::SRC_C: pick_duty = remote_two_duty_i;
        fpc_pkg::SRC_D: pick_duty = fpc_pkg::DUTY_FULL;
        fpc_pkg::SRC_E: pick_duty = fpc_pkg::DUTY_OFF;
        fpc_pkg::SRC_F: pick_duty = max8(local_duty_i, remote_two_duty_i);
        fpc_pkg::SRC_G: pick_duty = sens_max;
        fpc_pkg::SRC_H: pick_duty = man;
        default:        pick_duty = fpc_pkg::DUTY_FULL;
      endcase
    end
    else
    begin
      case (src_of(cfg))
        fpc_pkg::SRC_A: pick_duty = cpu_reading_zero_duty_i;
        fpc_pkg::SRC_B: pick_duty = cpu_reading_one_duty_i;
        fpc_pkg::SRC_C: pick_duty = cpu_reading_two_duty_i;
        fpc_pkg::SRC_D: pick_duty = cpu_reading_three_duty_i;
        fpc_pkg::SRC_F: pick_duty = cpu_max;
        fpc_pkg::SRC_H: pick_duty = max8(sens_max, cpu_max);
        default:        pick_duty = fpc_pkg::DUTY_FULL;
      endcase
    end
  endfunction : pick_duty

  // Register writes; lock makes the whole set read-only
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < fpc_pkg::NUM_CH; i++)
        cfg_r[i] <= fpc_pkg::RST_CFG;
      cpu_low_r <= fpc_pkg::RST_CPU_LOW;
    end
    else if (reg_wr_i && !lock_i)
    begin
      case (reg_addr_i)
        fpc_pkg::OFS_CPU_LOW: cpu_low_r <= reg_wdata_i;
        fpc_pkg::OFS_CFG_ONE: cfg_r[0]  <= reg_wdata_i;
        fpc_pkg::OFS_CFG_TWO: cfg_r[1]  <= reg_wdata_i;
        fpc_pkg::OFS_CFG_THR: cfg_r[2]  <= reg_wdata_i;
        default:              cpu_low_r <= cpu_low_r;
      endcase
    end
  end

  // Read data, zero for unmapped offsets
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        fpc_pkg::OFS_CPU_LOW: reg_rdata_o <= cpu_low_r;
        fpc_pkg::OFS_CFG_ONE: reg_rdata_o <= cfg_r[0];
        fpc_pkg::OFS_CFG_TWO: reg_rdata_o <= cfg_r[1];
        fpc_pkg::OFS_CFG_THR: reg_rdata_o <= cfg_r[2];
        default:              reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Shared millisecond tick
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      ms_cnt_r  <= 32'h0;
      ms_tick_r <= 1'b0;
    end
    else if (ms_cnt_r == 32'(MS_CYCLES - 1))
    begin
      ms_cnt_r  <= 32'h0;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      ms_cnt_r  <= ms_cnt_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  // Fan_speed_input pins are asynchronous; third stage only feeds the edge detect
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
    end
    else
    begin
      sync1_r <= fan_speed_input_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign fan_speed_input_rise = sync2_r & ~sync3_r;

  // Spin-up sequence per channel
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < fpc_pkg::NUM_CH; i++)
      begin
        su_r[i]    <= fpc_pkg::SU_SPIN;
        el_ms_r[i] <= 12'h000;
        edges_r[i] <= 2'h0;
      end
      hold_r    <= 3'h7;
      was_off_r <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < fpc_pkg::NUM_CH; i++)
      begin
        was_off_r[i] <= is_off(cfg_r[i]);
        // Restart on request or when leaving the off state
        if (spin_req_i[i] || (was_off_r[i] && !is_off(cfg_r[i])))
        begin
          su_r[i]    <= fpc_pkg::SU_SPIN;
          el_ms_r[i] <= 12'h000;
          edges_r[i] <= 2'h0;
          hold_r[i]  <= (cfg_r[i][fpc_pkg::SPIN_LSB +: fpc_pkg::SPIN_W] != fpc_pkg::SPIN_NONE);
        end
        else
        begin
          case (su_r[i])
            fpc_pkg::SU_SPIN:
            begin
              if (fan_speed_input_rise[i] && edges_r[i] != fpc_pkg::EDGES_OK)
                edges_r[i] <= edges_r[i] + 2'h1;
              if (ms_tick_r)
                el_ms_r[i] <= el_ms_r[i] + 12'h001;
              if (cfg_r[i][fpc_pkg::SPIN_LSB +: fpc_pkg::SPIN_W] == fpc_pkg::SPIN_NONE)
              begin
                su_r[i]   <= fpc_pkg::SU_IDLE;
                hold_r[i] <= 1'b0;
              end
              else if (edges_r[i] == fpc_pkg::EDGES_OK)
              begin
                su_r[i]   <= fpc_pkg::SU_IDLE;
                hold_r[i] <= 1'b0;
              end
              else if (el_ms_r[i] >= spin_ms(cfg_r[i][fpc_pkg::SPIN_LSB +: fpc_pkg::SPIN_W]))
              begin
                su_r[i]   <= fpc_pkg::SU_MEAS;
                hold_r[i] <= 1'b0;
              end
            end
            fpc_pkg::SU_MEAS:
              if (meas_done_i[i])
                su_r[i] <= fpc_pkg::SU_IDLE;
            fpc_pkg::SU_IDLE:
              su_r[i] <= fpc_pkg::SU_IDLE;
            default:
              su_r[i] <= fpc_pkg::SU_IDLE;
          endcase
        end
      end
    end
  end

  // Count override for the first measurement after a failed spin-up
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      ovr_r <= 3'h0;
    else
      for (int i = 0; i < fpc_pkg::NUM_CH; i++)
        if (meas_done_i[i])
          ovr_r[i] <= (su_r[i] == fpc_pkg::SU_MEAS) && !fan_speed_input_valid_i[i];
  end

  // Sticky fault; a new fault wins over a clear in the same cycle
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      fault_r <= 3'h0;
    else
      for (int i = 0; i < fpc_pkg::NUM_CH; i++)
        if (meas_done_i[i] && su_r[i] == fpc_pkg::SU_MEAS && !fan_speed_input_valid_i[i])
          fault_r[i] <= 1'b1;
        else if (fault_clr_i[i])
          fault_r[i] <= 1'b0;
  end

  // Registered outputs
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      duty_o          <= '0;
      polarity_flip_o <= 3'h0;
      spin_hold_o     <= 3'h0;
      channel_off_o   <= 3'h0;
      manual_mode_o   <= 3'h0;
      fan_speed_input_count_o    <= '0;
      fan_fault_o     <= 3'h0;
      cpu_low_limit_o <= fpc_pkg::RST_CPU_LOW;
    end
    else
    begin
      cpu_low_limit_o <= cpu_low_r;
      for (int i = 0; i < fpc_pkg::NUM_CH; i++)
      begin
        // Spin-up forces full drive regardless of source
        duty_o[i]          <= hold_r[i] ? fpc_pkg::DUTY_FULL : pick_duty(cfg_r[i], manual_duty_i[i]);
        spin_hold_o[i]     <= hold_r[i];
        polarity_flip_o[i] <= cfg_r[i][fpc_pkg::FLIP_BIT];
        channel_off_o[i]   <= is_off(cfg_r[i]);
        manual_mode_o[i]   <= is_manual(cfg_r[i]);
        fan_speed_input_count_o[i]    <= ovr_r[i] ? fpc_pkg::FAN_SPEED_INPUT_ALL1 : fan_speed_input_count_i[i];
        fan_fault_o[i]     <= fault_r[i] && (fan_speed_input_min_i[i] != fpc_pkg::FAN_SPEED_INPUT_ALL1)
                              && (fan_speed_input_min_i[i] != fpc_pkg::FAN_SPEED_INPUT_ALL0);
      end
    end
  end

endmodule : fpc_channel_config

// File: verification/fpc_channel_config_props.sv
// Checker on the channel configuration ports
`timescale 1ns/10ps
module fpc_channel_config_props (
  // Clock, reset, register port and fan_speed_input_min_i
  input wire logic             clock_i,
  input wire logic             sys_rst_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             lock_i,
  input wire logic [2:0][15:0] fan_speed_input_min_i,
  // Channel results
  input wire logic [2:0][7:0]  duty_o,
  input wire logic [2:0]       polarity_flip_o,
  input wire logic [2:0]       spin_hold_o,
  input wire logic [2:0]       channel_off_o,
  input wire logic [2:0][15:0] fan_speed_input_count_o,
  input wire logic [2:0]       fan_fault_o,
  input wire logic [7:0]       cpu_low_limit_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // Unlocked write strobes as causes
  logic wr_cfg;
  logic wr_cpu;
  assign wr_cfg = reg_wr_i && !lock_i && reg_addr_i == 8'h5c;
  assign wr_cpu = reg_wr_i && !lock_i && reg_addr_i == 8'h34;
  property p_lock;
    lock_i && reg_wr_i |=> $stable(cpu_low_limit_o) [*2];
  endproperty
  a_lock: assert property (p_lock) else $error("limit moved while locked");
  property p_cpu;
    wr_cpu ##1 !reg_wr_i [*2] |-> cpu_low_limit_o == $past(reg_wdata_i, 2);
  endproperty
  a_cpu: assert property (p_cpu) else $error("limit write lost");
  property p_flip;
    wr_cfg |-> ##2 polarity_flip_o[0] == $past(reg_wdata_i[4], 2);
  endproperty
  a_flip: assert property (p_flip) else $error("polarity wrong");
  property p_full;
    wr_cfg && reg_wdata_i[7:5] == 3'h3 && !reg_wdata_i[3] |-> ##2 duty_o[0] == 8'hff;
  endproperty
  a_full: assert property (p_full) else $error("full speed wrong");
  property p_off;
    channel_off_o[0] |-> duty_o[0] == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel drives");
  property p_spin;
    $rose(spin_hold_o[0]) |=> spin_hold_o[0] [*3];
  endproperty
  a_spin: assert property (p_spin) else $error("hold dropped early");
  property p_mask;
    (fan_speed_input_min_i[2] == 16'hffff || fan_speed_input_min_i[2] == 16'h0000) [*2] |-> !fan_fault_o[2];
  endproperty
  a_mask: assert property (p_mask) else $error("masked fault shown");
  property p_dead;
    $rose(fan_fault_o[1]) |-> ##[0:2] fan_speed_input_count_o[1] == 16'hffff;
  endproperty
  a_dead: assert property (p_dead) else $error("dead fan count wrong");
  c_fault: cover property ($rose(fan_fault_o[1]));
  c_spin: cover property ($fell(spin_hold_o[0]));
  c_off: cover property (channel_off_o[0]);
endmodule : fpc_channel_config_props
bind fpc_channel_config fpc_channel_config_props fpc_channel_config_props_inst (.*);

// File: verification/fpc_fan_model.sv
// Fan model: fan_speed_input toggles while running, rests low when stopped
`timescale 1ns/10ps
module fpc_fan_model (
  // Clock and fan control
  input  wire logic       clock_i,
  input  wire logic [2:0] run_i,
  // Fan_speed_input pins
  output logic      [2:0] fan_speed_input_o
);
  logic [1:0] cnt_r = 2'h0;
  logic [2:0] pin_r = 3'h0;
  always_ff @(posedge clock_i)
  begin
    cnt_r <= cnt_r + 2'h1;
    if (cnt_r == 2'h0)
      pin_r <= run_i & ~pin_r;
  end
  assign fan_speed_input_o = pin_r;
endmodule : fpc_fan_model

// File: verification/fan_pwm_channel_config_test.sv
// Testbench for the fan channel configuration block
`timescale 1ns/10ps
module fan_pwm_channel_config_test;
  logic             clock_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [7:0]       reg_addr_i = 8'h00;
  logic [7:0]       reg_wdata_i = 8'h00;
  logic             reg_wr_i = 1'b0;
  logic             reg_rd_i = 1'b0;
  logic             lock_i = 1'b0;
  logic [7:0]       reg_rdata_o, cpu_low_limit_o;
  logic [7:0]       remote_one_duty_i = 8'h90, local_duty_i = 8'h10, remote_two_duty_i = 8'h20;
  logic [7:0]       cpu_reading_zero_duty_i = 8'h40, cpu_reading_one_duty_i = 8'h60;
  logic [7:0]       cpu_reading_two_duty_i = 8'h50, cpu_reading_three_duty_i = 8'h45;
  logic [2:0][7:0]  manual_duty_i = {8'h82, 8'h81, 8'h80};
  logic [2:0]       fan_speed_input_i, spin_req_i = 3'h0, meas_done_i = 3'h0;
  logic [2:0]       fan_speed_input_valid_i = 3'h0, fault_clr_i = 3'h0;
  logic [2:0][15:0] fan_speed_input_count_i = {3{16'h0123}};
  logic [2:0][15:0] fan_speed_input_min_i = {16'hffff, 16'h1000, 16'h1000};
  logic [2:0][7:0]  duty_o;
  logic [2:0]       polarity_flip_o, spin_hold_o, channel_off_o, manual_mode_o, fan_fault_o;
  logic [2:0][15:0] fan_speed_input_count_o;
  // Expected duty per {table, source code}
  logic [7:0]       ex [16] = '{8'h90, 8'h10, 8'h20, 8'hff, 8'h00, 8'h20, 8'h90, 8'h80,
                                8'h40, 8'h60, 8'h50, 8'h45, 8'hff, 8'h60, 8'hff, 8'h90};
  int               n_mismatch = 0;
  int               samples_checked = 0;

  // Short timeout tick keeps spin-up within a few thousand cycles
  fpc_channel_config #(.MS_CYCLES(10)) fpc_channel_config_inst (.*);
  // Only fan one spins, so two and three hit the timeout
  fpc_fan_model fpc_fan_model_inst (.clock_i(clock_i), .run_i(3'b001), .fan_speed_input_o(fan_speed_input_i));

  always #2 clock_i = ~clock_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
      n_mismatch++;
    if (got !== exp)
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i   <= 1'b0;
    @(posedge clock_i);
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask : rd

  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(8'h5c, 8'h62);
    rd(8'h5d, 8'h62);
    rd(8'h5e, 8'h62);
    rd(8'h34, 8'h81);
    rd(8'h00, 8'h00);
    repeat (2430) @(posedge clock_i);
    #1;
    chk({13'h0, spin_hold_o}, 16'h0006);
    repeat (85) @(posedge clock_i);
    #1;
    chk({13'h0, spin_hold_o}, 16'h0000);
    @(posedge clock_i);
    meas_done_i  <= 3'h7;
    fan_speed_input_valid_i <= 3'h1;
    @(posedge clock_i);
    meas_done_i  <= 3'h0;
    repeat (3) @(posedge clock_i);
    #1;
    chk({13'h0, fan_fault_o}, 16'h0002);
    chk(fan_speed_input_count_o[1], 16'hffff);
    chk(fan_speed_input_count_o[0], 16'h0123);
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h5c, {i[2:0], i[0], i[3], 3'h0});
      repeat (3) @(posedge clock_i);
      #1;
      chk({8'h00, duty_o[0]}, {8'h00, ex[i]});
      chk({13'h0, channel_off_o[0], manual_mode_o[0], polarity_flip_o[0]}, {13'h0, i == 4, i == 7, i[0]});
    end
    @(posedge clock_i);
    lock_i <= 1'b1;
    wr(8'h5d, 8'h00);
    wr(8'h34, 8'h00);
    rd(8'h5d, 8'h62);
    rd(8'h34, 8'h81);
    @(posedge clock_i);
    lock_i <= 1'b0;
    wr(8'h34, 8'h7e);
    rd(8'h34, 8'h7e);
    chk({8'h00, cpu_low_limit_o}, 16'h007e);
    // Zero limit also hides the sticky fault; then clear it
    @(posedge clock_i);
    fan_speed_input_min_i[1] <= 16'h0000;
    repeat (2) @(posedge clock_i);
    #1;
    chk({13'h0, fan_fault_o}, 16'h0000);
    @(posedge clock_i);
    fault_clr_i <= 3'h2;
    @(posedge clock_i);
    fault_clr_i    <= 3'h0;
    fan_speed_input_min_i[1] <= 16'h1000;
    repeat (2) @(posedge clock_i);
    #1;
    chk({13'h0, fan_fault_o}, 16'h0000);
    // Restart channel two with the shortest timeout, no fan attached
    wr(8'h5d, 8'h61);
    @(posedge clock_i);
    spin_req_i <= 3'h2;
    @(posedge clock_i);
    spin_req_i <= 3'h0;
    repeat (900) @(posedge clock_i);
    #1;
    chk({13'h0, spin_hold_o}, 16'h0002);
    repeat (120) @(posedge clock_i);
    #1;
    chk({13'h0, spin_hold_o}, 16'h0000);
    @(posedge clock_i);
    meas_done_i  <= 3'h2;
    fan_speed_input_valid_i <= 3'h2;
    @(posedge clock_i);
    meas_done_i  <= 3'h0;
    repeat (2) @(posedge clock_i);
    #1;
    chk(fan_speed_input_count_o[1], 16'h0123);
    chk({13'h0, fan_fault_o}, 16'h0000);
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    test_done;
  end
endmodule : fan_pwm_channel_config_test
